// file: mub_port.sv
// muxed address/data utility bus slave port, device side
`timescale 1ns/1ps
// =====================================================================
// Summary of operation
// RQ1: address captured on falling latch strobe
// RQ2: drive bus only during read access
// RQ3: write data taken at write completion
// RQ4: host keeps latch low during data
// RQ5: no access without chip select
// RQ6: chip select may stay asserted always
// RQ7: strobes synchronised into clock domain
// RQ8: host reads with read strobe and select
// RQ9: write sampled when strobe or select ends
// RQ10: address held until next latch fall
//
// pins reach the logic two edges late through the synchronisers
// bus value is taken one edge before a strobe change is seen,
// so a strobe that arrives late never grabs lines already moving
// one register fetch per read; data holds until the next read
// lines are driven only while a selected read stands
// select tied low works: the strobes alone frame each access
module mub_port
    import mub_pkg::*;
#(
    parameter int AW = MUB_AW,
    parameter int DW = MUB_DW
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [DW-1:0] ad_in,
    output logic [DW-1:0] ad_out,
    output logic ad_oe,
    input wire logic ale,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [AW-1:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [DW-1:0] reg_wdata,
    input wire logic [DW-1:0] reg_rdata
);
    // =================================================================
    // synchronisers
    // every pin crosses in two flops; nothing reads the first stage
    // the data bits settle one by one, so they are taken a cycle late
    logic ale_s, cs_n_s, rd_n_s, wr_n_s;
    logic [DW-1:0] ad_s;

    mub_sync #(.RST_VAL(1'b0)) u_ale (.clk(clk), .sys_rst(sys_rst), .d_async(ale),
        .q_sync(ale_s)); // RQ7
    mub_sync #(.RST_VAL(1'b1)) u_cs (.clk(clk), .sys_rst(sys_rst), .d_async(cs_n),
        .q_sync(cs_n_s)); // RQ7
    mub_sync #(.RST_VAL(1'b1)) u_rd (.clk(clk), .sys_rst(sys_rst), .d_async(rd_n),
        .q_sync(rd_n_s));
    mub_sync #(.RST_VAL(1'b1)) u_wr (.clk(clk), .sys_rst(sys_rst), .d_async(wr_n),
        .q_sync(wr_n_s));

    // address/data lines, one synchroniser per bit
    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++) begin : g_ad
            mub_sync #(.RST_VAL(1'b0)) u_ad (.clk(clk), .sys_rst(sys_rst),
                .d_async(ad_in[gi]), .q_sync(ad_s[gi]));
        end
    endgenerate

    // =================================================================
    // state
    // edge detectors reset to the idle level of their pins: no false edge
    typedef struct packed {
        logic ale_d;
        logic rd_act_d;
        logic wr_act_d;
        logic [DW-1:0] ad_d;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic [DW-1:0] rdata;
        logic oe;
        logic rd_p;
        logic wr_p;
    } mub_port_s;
    mub_port_s st_reg;
    mub_port_s st_next;

    logic rd_act, wr_act;
    // select qualifies both strobes; a tied-low select leaves strobes alone
    assign rd_act = ~cs_n_s & ~rd_n_s & wr_n_s & ~ale_s; // RQ5 RQ6 RQ8
    assign wr_act = ~cs_n_s & ~wr_n_s & rd_n_s & ~ale_s; // RQ5 RQ6 RQ9

    // =================================================================
    // next state
    // read and write strobes low together is neither access
    always_comb begin
        st_next = st_reg;
        st_next.ale_d = ale_s;
        st_next.rd_act_d = rd_act;
        st_next.wr_act_d = wr_act;
        st_next.ad_d = ad_s;
        st_next.rd_p = 1'b0;
        st_next.wr_p = 1'b0;
        // falling latch strobe: take bus value seen one cycle earlier
        if (st_reg.ale_d && !ale_s) begin
            st_next.addr = AW'(st_reg.ad_d); // RQ1 RQ10
        end
        // read start: fetch register once, then drive it
        if (rd_act && !st_reg.rd_act_d) begin
            st_next.rd_p = 1'b1;
        end
        if (st_reg.rd_p) begin
            st_next.rdata = reg_rdata;
        end
        st_next.oe = st_reg.rd_act_d & rd_act; // RQ2
        // write end: strobe or select released
        if (st_reg.wr_act_d && !wr_act) begin
            st_next.wdata = st_reg.ad_d; // RQ3 RQ9
            st_next.wr_p = 1'b1;
        end
    end

    // synchronous reset; the whole state struct in one register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{ale_d: 1'b0, rd_act_d: 1'b0, wr_act_d: 1'b0,
                ad_d: DW'(MUB_DATA_RST), addr: AW'(MUB_ADDR_RST), wdata: DW'(MUB_DATA_RST),
                rdata: DW'(MUB_DATA_RST), oe: 1'b0, rd_p: 1'b0, wr_p: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // =================================================================
    // outputs
    // write data holds after the pulse, so slow register logic may take it late
    assign ad_out = st_reg.rdata;
    assign ad_oe = st_reg.oe; // RQ2
    assign reg_addr = st_reg.addr;
    assign reg_rd = st_reg.rd_p;
    assign reg_wr = st_reg.wr_p;
    assign reg_wdata = st_reg.wdata;

    // =================================================================
    // assertions
    sequence s_wr_end;
        $past(wr_act) && !wr_act;
    endsequence

    // read start as the logic sees it, after the synchronisers
    sequence s_rd_start;
        rd_act && !$past(rd_act);
    endsequence

    a_oe_needs_read: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        ad_oe |-> $past(rd_act))
        else $error("bus driven outside read");
    a_addr_on_fall: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
        ($past(ale_s) && !ale_s) |=> reg_addr == $past(ad_s, 2))
        else $error("address not captured");
    a_addr_holds: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
        !($past(ale_s) && !ale_s) |=> $stable(reg_addr))
        else $error("address changed without latch");
    a_wr_at_end: assert property (@(posedge clk) disable iff (sys_rst) // RQ3 RQ9
        s_wr_end |=> reg_wr && reg_wdata == $past(ad_s, 2))
        else $error("write not taken at end");
    a_no_cs_access: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        cs_n_s [*3] |-> !reg_rd && !ad_oe)
        else $error("access without select");
    a_wr_pulse_one: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
        reg_wr |=> !reg_wr)
        else $error("write pulse too long");
    a_rd_then_oe: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        (reg_rd && rd_act) |=> ad_oe)
        else $error("read data not driven");
    a_wr_no_oe: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        wr_act |=> !ad_oe)
        else $error("driving during write");

    // read fetch and bus drive timing
    a_rd_pulse: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
        s_rd_start |=> reg_rd)
        else $error("no fetch at read start");
    a_rd_pulse_one: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
        reg_rd |=> !reg_rd)
        else $error("fetch pulse too long");
    a_rd_data_load: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        reg_rd |=> ad_out == $past(reg_rdata))
        else $error("read data not loaded");
    a_oe_late: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        s_rd_start |=> !ad_oe)
        else $error("stale data driven");
    a_oe_on_read: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        s_rd_start ##1 rd_act |=> ad_oe)
        else $error("read data not driven in time");
    a_oe_drops: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        !rd_act |=> !ad_oe)
        else $error("bus held after read");

    // select and latch gate every access
    a_rd_needs_cs: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        reg_rd |-> !$past(cs_n_s))
        else $error("fetch without select");
    a_wr_needs_cs: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        reg_wr |-> !$past(cs_n_s, 2))
        else $error("write without select");
    a_no_cs_write: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        cs_n_s [*3] |-> !reg_wr)
        else $error("write while deselected");
    a_oe_needs_sel: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        ad_oe |-> !$past(cs_n_s))
        else $error("bus driven while deselected");
    a_ale_no_access: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
        ale_s [*3] |-> !reg_rd && !reg_wr)
        else $error("access during address phase");

    // write path
    a_tied_cs_write: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
        ((!cs_n_s) [*2] ##0 s_wr_end) |=> reg_wr)
        else $error("strobe-ended write lost");
    a_wdata_holds: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
        !($past(wr_act) && !wr_act) |=> $stable(reg_wdata))
        else $error("write data changed between writes");
endmodule

// file: mub_pkg.sv
// package for the muxed utility bus port: widths and sync depth
package mub_pkg;
    localparam int MUB_AW = 8;
    localparam int MUB_DW = 8;
    localparam int MUB_SYNC_STAGES = 2;
    localparam logic [7:0] MUB_ADDR_RST = 8'h00;
    localparam logic [7:0] MUB_DATA_RST = 8'h00;
endpackage

// file: mub_sync.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module mub_sync
    import mub_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic d_async,
    output logic q_sync
);
    typedef struct packed {
        logic meta;
        logic stab;
    } mub_sync_s;
    mub_sync_s st_reg;
    mub_sync_s st_next;

    // first stage only feeds the second
    always_comb begin
        st_next.meta = d_async;
        st_next.stab = st_reg.meta;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{meta: RST_VAL, stab: RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_sync = st_reg.stab;
endmodule

// file: mub_host.sv
// host model that drives the muxed utility bus
`timescale 1ns/1ps
module mub_host
    import mub_pkg::*;
(
    input wire logic clk,
    input wire logic [MUB_DW-1:0] ad_out,
    input wire logic ad_oe,
    output logic [MUB_DW-1:0] ad_in,
    output logic ale,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n
);
    logic [7:0] drv = 8'h00;
    logic [7:0] flt = 8'h5a;
    logic hdrv = 1'b0;
    logic keep_cs = 1'b0;
    initial begin
        ale = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
    end
    // released lines wander so a stale value never looks valid
    always @(negedge clk) flt <= ~flt;
    assign ad_in = ad_oe ? ad_out : (hdrv ? drv : flt);
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // address phase, latch low before data
    task automatic addr(input logic [7:0] a);
        drv = a;
        hdrv = 1'b1;
        ale = 1'b1;
        wt(4);
        ale = 1'b0;
        wt(4);
        hdrv = 1'b0;
        wt(2);
    endtask
    // write: bad data first, good data at the end
    task automatic write(input logic [7:0] d, input logic sel, input logic cs_end);
        drv = ~d;
        hdrv = 1'b1;
        cs_n = !sel;
        wr_n = 1'b0;
        wt(2);
        drv = d;
        wt(4);
        if (cs_end) cs_n = 1'b1;
        else wr_n = 1'b1;
        wt(4);
        wr_n = 1'b1;
        cs_n = !keep_cs;
        hdrv = 1'b0;
        wt(4);
    endtask
    // read: write strobe idle, read strobe with select
    task automatic read(output logic [7:0] q, output logic oe);
        cs_n = 1'b0;
        rd_n = 1'b0;
        wt(5);
        q = ad_out;
        oe = ad_oe;
        rd_n = 1'b1;
        cs_n = !keep_cs;
        wt(4);
    endtask
endmodule

// file: muxed_utility_bus_port_tb.sv
// self-checking bench for the muxed utility bus port
`timescale 1ns/1ps
module muxed_utility_bus_port_tb;
    import mub_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] ad_in, ad_out, reg_addr, reg_wdata, reg_rdata, wa, wd, q;
    logic ad_oe, ale, cs_n, rd_n, wr_n, reg_rd, reg_wr, oe;
    logic [7:0] regs [256];
    int n_mismatch = 0;
    int n_compared = 0;
    int n_wr = 0;
    int ew = 0;
    int n_rd = 0;
    int er = 0;
    always #12.5 clk = ~clk;
    mub_port i_mub_port (.clk(clk), .sys_rst(sys_rst), .ad_in(ad_in), .ad_out(ad_out),
        .ad_oe(ad_oe), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    mub_host i_mub_host (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .ale(ale),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
    // register file behind the port
    assign reg_rdata = regs[reg_addr];
    always @(posedge clk) begin
        if (reg_wr) begin
            regs[reg_addr] <= reg_wdata;
            wa <= reg_addr;
            wd <= reg_wdata;
            n_wr++;
        end
        if (reg_rd) n_rd++;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // write count, address and data of the last write
    task automatic cw(input logic [7:0] a, input logic [7:0] d);
        chk("writes", 8'(ew), 8'(n_wr));
        chk("waddr", a, wa);
        chk("wdata", d, wd);
    endtask
    // read, then bus released
    task automatic cr(input logic [7:0] d);
        i_mub_host.read(q, oe);
        er++;
        chk("reads", 8'(er), 8'(n_rd));
        chk("rdata", d, q);
        chk("oe", 8'h01, {7'h00, oe});
        chk("idle oe", 8'h00, {7'h00, ad_oe});
    endtask
    // write ended by strobe, two reads on one address
    task automatic t_wr_rd;
        chk("rst oe", 8'h00, {7'h00, ad_oe});
        i_mub_host.addr(8'h3c);
        i_mub_host.write(8'ha5, 1'b1, 1'b0);
        ew++;
        cw(8'h3c, 8'ha5);
        cr(8'ha5);
        cr(8'ha5);
    endtask
    // unselected write, then write ended by select
    task automatic t_sel;
        i_mub_host.write(8'h11, 1'b0, 1'b0);
        cw(8'h3c, 8'ha5);
        i_mub_host.addr(8'h81);
        i_mub_host.write(8'h5e, 1'b1, 1'b1);
        ew++;
        cw(8'h81, 8'h5e);
    endtask
    // select held low all along
    task automatic t_tied;
        i_mub_host.keep_cs = 1'b1;
        i_mub_host.cs_n = 1'b0;
        i_mub_host.addr(8'h07);
        i_mub_host.write(8'hc3, 1'b1, 1'b0);
        ew++;
        cw(8'h07, 8'hc3);
        cr(8'hc3);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        t_wr_rd();
        t_sel();
        t_tied();
        test_done();
    end
endmodule
